/* File: rtl/skip_test_pkg.sv */
// Constants and carrier types for the conditional-skip instruction decoder.
// Assumes a 10-bit instruction word and a 32-bit AHB-Lite register bus.
package skip_test_pkg;

  // ---------------------------------------------------------------
  // Instruction encodings
  // ---------------------------------------------------------------
  localparam logic [9:0] OP_PIN_A_LEVEL = 10'h03a;
  localparam logic [9:0] OP_PIN_B_LEVEL = 10'h03b;

  // ---------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_A_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PIN_B_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CTRL_V     = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0c;
  localparam int         CTRL_W          = 4;
  localparam int         POL_BIT         = 2;
  localparam int         TMR1_EN_BIT     = 2;
  localparam int         ST_PD           = 0;
  localparam int         ST_TMR1         = 1;
  localparam int         ST_SKIP         = 2;
  localparam int         ST_PIN_A        = 3;
  localparam int         ST_PIN_B        = 4;
  localparam logic [3:0] CTRL_RESET      = 4'h0;
  localparam int         SYNC_STAGES     = 3;

  // AHB-Lite transfer type bit that marks an active transfer
  localparam int         HTRANS_ACTIVE   = 1;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [9:0] word;
  } fetch_type;

  typedef struct packed {
    logic exec_ok;
    logic squash;
  } issue_type;

endpackage

/* File: rtl/skip_test_instructions.sv */
// Decode and execute logic for the pin-level, power-down and timer 1
// conditional-skip instructions, with an AHB-Lite control/status slave.
// Assumes words arrive from the fetch path on hclk, one per valid cycle.
//
// How it works
// - Word 0x03a is the pin A level test: one word, one cycle.
// - Pin A test skips on low when polarity bit 2 is 0, on high when 1.
// - Word 0x03b is the pin B level test: one word, one cycle.
// - Pin B test skips on low when its polarity bit is 0, high when 1.
// - Power-down test skips when the flag is 1 and never changes it.
// - Timer 1 test, enable 0: flag 1 clears it and skips; flag 0 runs on.
// - Timer 1 test with enable 1 is a no-op: no skip, flag untouched.
// - Power-down and timer 1 tests: one word, one cycle, carry untouched.
`timescale 1ns/1ns
module skip_test_instructions #(
  parameter logic [9:0] OP_POWERDOWN = 10'h003,
  parameter logic [9:0] OP_TMR1      = 10'h280
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire skip_test_pkg::fetch_type fetch,
  input  wire logic                     ext_irq_pin_a,
  input  wire logic                     ext_irq_pin_b,
  input  wire logic                     powerdown_flag,
  input  wire logic                     tmr1_event,
  output skip_test_pkg::issue_type      issue,
  output logic                          tmr1_request_flag
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [skip_test_pkg::SYNC_STAGES-1:0] sync_a_ff;
  logic [skip_test_pkg::SYNC_STAGES-1:0] sync_b_ff;
  logic                                  pin_a_ff;
  logic                                  pin_b_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a_ff <= '0;
      sync_b_ff <= '0;
    end else begin
      sync_a_ff <= {sync_a_ff[1:0], ext_irq_pin_a};
      sync_b_ff <= {sync_b_ff[1:0], ext_irq_pin_b};
    end
  end

  // A level counts only once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_a_ff <= 1'b0;
      pin_b_ff <= 1'b0;
    end else begin
      if (sync_a_ff[1] == sync_a_ff[2]) begin
        pin_a_ff <= sync_a_ff[2];
      end
      if (sync_b_ff[1] == sync_b_ff[2]) begin
        pin_b_ff <= sync_b_ff[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [skip_test_pkg::CTRL_W-1:0] pin_a_irq_ctrl_reg_ff;
  logic [skip_test_pkg::CTRL_W-1:0] pin_b_irq_ctrl_reg_ff;
  logic [skip_test_pkg::CTRL_W-1:0] irq_ctrl_reg_v_ff;
  logic                             wr_pend_ff;
  logic [7:0]                       wr_addr_ff;

  logic pin_a_polarity_sel;
  logic pin_b_polarity_sel;
  logic tmr1_irq_enable;
  assign pin_a_polarity_sel = pin_a_irq_ctrl_reg_ff[skip_test_pkg::POL_BIT];
  assign pin_b_polarity_sel = pin_b_irq_ctrl_reg_ff[skip_test_pkg::POL_BIT];
  assign tmr1_irq_enable    = irq_ctrl_reg_v_ff[skip_test_pkg::TMR1_EN_BIT];

  logic addr_phase;
  assign addr_phase = hsel & hready & htrans[skip_test_pkg::HTRANS_ACTIVE];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_phase & hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_a_irq_ctrl_reg_ff <= skip_test_pkg::CTRL_RESET;
      pin_b_irq_ctrl_reg_ff <= skip_test_pkg::CTRL_RESET;
      irq_ctrl_reg_v_ff     <= skip_test_pkg::CTRL_RESET;
    end else if (wr_pend_ff) begin
      unique case (wr_addr_ff)
        skip_test_pkg::ADDR_PIN_A_CTRL: begin
          pin_a_irq_ctrl_reg_ff <= hwdata[skip_test_pkg::CTRL_W-1:0];
        end
        skip_test_pkg::ADDR_PIN_B_CTRL: begin
          pin_b_irq_ctrl_reg_ff <= hwdata[skip_test_pkg::CTRL_W-1:0];
        end
        skip_test_pkg::ADDR_CTRL_V: begin
          irq_ctrl_reg_v_ff <= hwdata[skip_test_pkg::CTRL_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Instruction decode and skip evaluation
  // ---------------------------------------------------------------
  logic skip_pending_ff;
  logic live;
  logic is_pin_a;
  logic is_pin_b;
  logic is_pd;
  logic is_tmr1;
  logic nxt_skip;
  logic tmr1_clear;

  // A word under a pending skip is dropped before decode
  assign live     = fetch.valid & ~skip_pending_ff;
  assign is_pin_a = live
                  & (fetch.word == skip_test_pkg::OP_PIN_A_LEVEL);
  assign is_pin_b = live
                  & (fetch.word == skip_test_pkg::OP_PIN_B_LEVEL);
  assign is_pd    = live & (fetch.word == OP_POWERDOWN);
  assign is_tmr1  = live & (fetch.word == OP_TMR1);

  // Enable high turns the timer 1 test into a plain no-op
  assign tmr1_clear = is_tmr1 & ~tmr1_irq_enable
                    & tmr1_request_flag;

  always_comb begin
    nxt_skip = 1'b0;
    if (is_pin_a) begin
      nxt_skip = (pin_a_ff == pin_a_polarity_sel);
    end else if (is_pin_b) begin
      nxt_skip = (pin_b_ff == pin_b_polarity_sel);
    end else if (is_pd) begin
      nxt_skip = powerdown_flag;
    end else if (is_tmr1) begin
      nxt_skip = tmr1_clear;
    end
  end

  // Pending skip lasts until the next valid word is dropped; one cycle each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip_pending_ff <= 1'b0;
    end else if (fetch.valid) begin
      skip_pending_ff <= nxt_skip;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      issue <= '0;
    end else begin
      issue.exec_ok <= live;
      issue.squash  <= fetch.valid & skip_pending_ff;
    end
  end

  // Timer 1 request: hardware set wins over any clear in the same cycle
  logic sw_tmr1_clear;
  assign sw_tmr1_clear = wr_pend_ff
                       & (wr_addr_ff == skip_test_pkg::ADDR_STATUS)
                       & hwdata[skip_test_pkg::ST_TMR1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr1_request_flag <= 1'b0;
    end else if (tmr1_event) begin
      tmr1_request_flag <= 1'b1;
    end else if (tmr1_clear | sw_tmr1_clear) begin
      tmr1_request_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read path: data readied in the address phase, zero wait states
  // ---------------------------------------------------------------
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (haddr[7:0])
      skip_test_pkg::ADDR_PIN_A_CTRL: begin
        nxt_rdata[skip_test_pkg::CTRL_W-1:0] = pin_a_irq_ctrl_reg_ff;
      end
      skip_test_pkg::ADDR_PIN_B_CTRL: begin
        nxt_rdata[skip_test_pkg::CTRL_W-1:0] = pin_b_irq_ctrl_reg_ff;
      end
      skip_test_pkg::ADDR_CTRL_V: begin
        nxt_rdata[skip_test_pkg::CTRL_W-1:0] = irq_ctrl_reg_v_ff;
      end
      skip_test_pkg::ADDR_STATUS: begin
        nxt_rdata[skip_test_pkg::ST_PD]    = powerdown_flag;
        nxt_rdata[skip_test_pkg::ST_TMR1]  = tmr1_request_flag;
        nxt_rdata[skip_test_pkg::ST_SKIP]  = skip_pending_ff;
        nxt_rdata[skip_test_pkg::ST_PIN_A] = pin_a_ff;
        nxt_rdata[skip_test_pkg::ST_PIN_B] = pin_b_ff;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_phase & ~hwrite) begin
        hrdata <= nxt_rdata;
      end
    end
  end

endmodule

/* File: sim/skip_checker.sv */
// Port-level checks of the skip decoder, bound to every instance.
// Assumes fetch idle and tmr1_event low while reset is held.
`timescale 1ns/1ns
module skip_checker #(
  parameter logic [9:0] OP_POWERDOWN = 10'h003,
  parameter logic [9:0] OP_TMR1      = 10'h280
) (
  input wire logic                     hclk,
  input wire logic                     hresetn,
  input wire logic                     hsel,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic                     hready,
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  input wire skip_test_pkg::fetch_type fetch,
  input wire logic                     powerdown_flag,
  input wire logic                     tmr1_event,
  input wire skip_test_pkg::issue_type issue,
  input wire logic                     tmr1_request_flag
);
  logic wr_ff;
  wire logic pd_op = fetch.valid && fetch.word == OP_POWERDOWN;
  wire logic t1_op = fetch.valid && fetch.word == OP_TMR1;
  // A software clear of the timer flag lands one edge after this
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_ff <= 1'b0;
    else wr_ff <= hsel & hready & htrans[1] & hwrite;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_ONE_ANSWER: assert property (fetch.valid
    |=> issue.exec_ok ^ issue.squash)
    else $error("fetched word without exactly one answer");
  AST_QUIET: assert property (!fetch.valid
    |=> !issue.exec_ok && !issue.squash)
    else $error("answer without a fetched word");
  AST_PD_SKIP: assert property (issue.exec_ok && $past(pd_op && powerdown_flag)
    && fetch.valid |=> issue.squash)
    else $error("power-down set but next word not squashed");
  AST_PD_RUN: assert property (issue.exec_ok && $past(pd_op && !powerdown_flag)
    && fetch.valid |=> issue.exec_ok)
    else $error("power-down clear but next word squashed");
  AST_T1_SKIP: assert property (issue.exec_ok && fetch.valid &&
    $past(t1_op && tmr1_request_flag && !tmr1_event)
    |=> issue.squash == !$past(tmr1_request_flag))
    else $error("timer skip and flag clear disagree");
  AST_FLAG_FALL: assert property ($fell(tmr1_request_flag)
    |-> $past(t1_op) || $past(wr_ff))
    else $error("timer flag cleared without cause");
  AST_EVENT_SETS: assert property (tmr1_event |=> tmr1_request_flag)
    else $error("timer event did not set flag");
  AST_OKAY: assert property ($past(hresetn) |-> hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule

bind skip_test_instructions skip_checker #(.OP_POWERDOWN(OP_POWERDOWN),
  .OP_TMR1(OP_TMR1)) u_chk (.*);

/* File: sim/prog_mem.sv */
// Program memory stand-in: one fetched word per request cycle.
// Assumes req and addr_word change just after a rising edge.
`timescale 1ns/1ns
module prog_mem (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                req,
  input  wire logic [9:0]          addr_word,
  output skip_test_pkg::fetch_type fetch
);
  // Idle cycles invert the word so a stale value is not held from one cycle to the next
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fetch <= '0;
    else begin
      fetch.valid <= req;
      fetch.word  <= req ? addr_word : ~fetch.word;
    end
  end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the skip decoder.
// Assumes the program memory model feeds fetch and hready loops back.
`timescale 1ns/1ns
module tb_top;
  localparam logic [9:0] OP_PD = 10'h003;
  localparam logic [9:0] OP_T1 = 10'h280;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        req = 1'b0, pin_a = 1'b0, pin_b = 1'b0, pd = 1'b0;
  logic        t1_ev = 1'b0, hreadyout, hresp, t1_flag;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [31:0] seed = 32'h00000046;
  logic [1:0]  htrans = '0;
  logic [9:0]  wd = '0;
  logic [1:0]  exp_q[$];
  int          miscompares = 0, checks = 0, cyc = 0;
  skip_test_pkg::fetch_type fetch;
  skip_test_pkg::issue_type issue;
  always #2 hclk = ~hclk;
  prog_mem u_mem (.hclk(hclk), .hresetn(hresetn), .req(req),
    .addr_word(wd), .fetch(fetch));
  skip_test_instructions #(.OP_POWERDOWN(OP_PD), .OP_TMR1(OP_T1)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fetch(fetch), .ext_irq_pin_a(pin_a),
    .ext_irq_pin_b(pin_b), .powerdown_flag(pd), .tmr1_event(t1_ev),
    .issue(issue), .tmr1_request_flag(t1_flag));
  function automatic logic [9:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[9:0];
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string nm);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic op(input logic [9:0] w, input logic [1:0] e);
    req <= 1'b1;
    wd <= w;
    exp_q.push_back(e);
    @(posedge hclk);
  endtask
  // Follow-up words sit in 0x300-0x3ff so they never skip themselves
  task automatic pair(input logic [9:0] w, input logic skip);
    logic [9:0] r;
    r = rnd();
    op(w, 2'b10);
    op({2'b11, r[7:0]}, skip ? 2'b01 : 2'b10);
    req <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  always @(posedge hclk) begin
    #1;
    if (issue !== 2'b00)
      chk({30'h0, issue}, {30'h0, exp_q.pop_front()}, "issue");
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h08, '0);
    chk(rd, '0, "ctrl v reset");
    bus(1'b0, 8'h10, '0);
    chk(rd, '0, "unmapped read");
    // Unselected pin sits at the opposite level to catch a crossed pin
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, i[2] ? 8'h04 : 8'h00, {29'h0, i[1], 2'h0});
      pin_a <= i[0] ^ i[2];
      pin_b <= i[0] ^ !i[2];
      repeat (6) @(posedge hclk);
      bus(1'b0, 8'h0c, '0);
      chk(32'(rd[4:3]), 32'({i[0] ^ !i[2], i[0] ^ i[2]}),
        "pin sync");
      pair(i[2] ? skip_test_pkg::OP_PIN_B_LEVEL
                : skip_test_pkg::OP_PIN_A_LEVEL,
        i[1] == i[0]);
    end
    for (int i = 0; i < 2; i++) begin
      pd <= i[0];
      @(posedge hclk);
      pair(OP_PD, i[0]);
      bus(1'b0, 8'h0c, '0);
      chk(32'(rd[0]), 32'(i[0]), "powerdown flag");
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h08, {29'h0, i[1], 2'h0});
      t1_ev <= i[0];
      @(posedge hclk);
      t1_ev <= 1'b0;
      @(posedge hclk);
      pair(OP_T1, i[0] && !i[1]);
      bus(1'b0, 8'h0c, '0);
      chk(32'(rd[1]), 32'(i[0] && i[1]), "tmr1 flag");
    end
    // Every word sent must have had its answer by now
    chk(32'(exp_q.size()), 32'h0, "answers outstanding");
    print_verdict();
  end
endmodule
